// ===== smr_icx.sv
`timescale 1ns/1ps
module smr_icx
   import smr_pkg::*;
(
   // Clock, reset and stall mode.
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic slow,
   // Response and data channels.
   input wire logic crvalid,
   output logic crready,
   input wire smr_resp_type crresp,
   input wire logic cdvalid,
   output logic cdready,
   input wire logic [SMR_DATA_W-1:0] cddata,
   input wire logic cdlast,
   // What the interconnect received.
   output smr_resp_type got_resp,
   output logic [SMR_DATA_W*SMR_BEATS-1:0] got_line,
   output int got_beats
);
   int beat;
   // Ready toggles in slow mode so every data beat is also tried against a stall.
   always_ff @(negedge clk_sys or posedge reset) begin
      if (reset) begin
         crready <= 1'b0;
         cdready <= 1'b0;
      end else begin
         crready <= slow ? ~crready : 1'b1;
         cdready <= slow ? ~cdready : 1'b1;
      end
   end
   // Any passed write-back duty is accepted as given.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         got_resp <= '0;
         got_line <= '0;
         got_beats <= 0;
         beat <= 0;
      end else begin
         if (crvalid && crready) got_resp <= crresp;
         if (cdvalid && cdready) begin
            got_line[beat*SMR_DATA_W +: SMR_DATA_W] <= cddata;
            beat <= cdlast ? 0 : beat + 1;
            got_beats <= got_beats + 1;
         end
      end
   end
endmodule

// ===== smr_pkg.sv
package smr_pkg;

   // Bus and line geometry.
   localparam int SMR_ADDR_W = 32;
   localparam int SMR_DATA_W = 64;
   localparam int SMR_BEATS = 4;
   localparam int SMR_ID_W = 3;
   localparam int SMR_LINE_OFF = 6;
   localparam int SMR_SNOOP_W = 4;

   // Snoop type codes as carried on the snoop address channel.
   localparam logic [SMR_SNOOP_W-1:0] SMR_SN_READ_ONCE = 4'h0;
   localparam logic [SMR_SNOOP_W-1:0] SMR_SN_READ_SHARED = 4'h1;
   localparam logic [SMR_SNOOP_W-1:0] SMR_SN_READ_CLEAN = 4'h2;
   localparam logic [SMR_SNOOP_W-1:0] SMR_SN_READ_NSD = 4'h3;

   // Cache line states.
   typedef enum logic [2:0] {
      SMR_LS_I = 3'h0,
      SMR_LS_UC = 3'h1,
      SMR_LS_UD = 3'h2,
      SMR_LS_SC = 3'h3,
      SMR_LS_SD = 3'h4
   } smr_line_type;

   // Guess of which master stores to the line next.
   typedef enum logic [1:0] {
      SMR_HINT_UNKNOWN = 2'h0,
      SMR_HINT_SNOOPED = 2'h1,
      SMR_HINT_INITIATOR = 2'h2
   } smr_hint_type;

   // Kinds of the master's own write-address transactions.
   typedef enum logic [2:0] {
      SMR_WR_NOSNOOP = 3'h0,
      SMR_WR_BACK = 3'h1,
      SMR_WR_CLEAN = 3'h2,
      SMR_WR_EVICT = 3'h3,
      SMR_WR_EVICT_ONLY = 3'h4,
      SMR_WR_UNIQUE = 3'h5,
      SMR_WR_LINE_UNIQUE = 3'h6,
      SMR_WR_OTHER = 3'h7
   } smr_wkind_type;

   // Snoop response, bit 4 first.
   typedef struct packed {
      logic was_unique;
      logic is_shared;
      logic pass_dirty;
      logic error;
      logic data_xfer;
   } smr_resp_type;

   // Outcome of one snoop: new line state and response.
   typedef struct packed {
      smr_line_type end_state;
      smr_resp_type resp;
   } smr_plan_type;

   // Start of one of the master's own writes.
   typedef struct packed {
      logic valid;
      logic [SMR_ID_W-1:0] id;
      logic [SMR_ADDR_W-1:0] addr;
      smr_wkind_type kind;
   } smr_wreq_type;

   // Main controller states, one-hot.
   typedef enum logic [4:0] {
      SMR_ST_IDLE = 5'h01,
      SMR_ST_LOOKUP = 5'h02,
      SMR_ST_DECIDE = 5'h04,
      SMR_ST_RESP = 5'h08,
      SMR_ST_DATA = 5'h10
   } smr_state_type;

   function automatic logic smr_valid(input smr_line_type s);
      return s != SMR_LS_I;
   endfunction

   function automatic logic smr_dirty(input smr_line_type s);
      return (s == SMR_LS_UD) || (s == SMR_LS_SD);
   endfunction

   function automatic logic smr_unique(input smr_line_type s);
      return (s == SMR_LS_UC) || (s == SMR_LS_UD);
   endfunction

endpackage

// ===== smr_props.sv
`timescale 1ns/1ps
module smr_props
   import smr_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Snoop channels.
   input wire logic acvalid,
   input wire logic acready,
   input wire logic [SMR_SNOOP_W-1:0] acsnoop,
   input wire logic crvalid,
   input wire logic crready,
   input wire smr_resp_type crresp,
   input wire logic cdvalid,
   input wire logic cdready,
   input wire logic cdlast,
   // Cache port.
   input wire logic cache_ack,
   input wire smr_line_type cache_state,
   input wire logic cache_excl,
   input wire logic cache_upd,
   input wire smr_line_type cache_new_state,
   input wire logic snoop_busy
);
   logic [SMR_SNOOP_W-1:0] kind_q;
   logic dirty_q, excl_q, rd_multi, end_dirty;
   logic [1:0] beats;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Snoop facts are latched because the answer comes cycles after they were seen.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         kind_q <= '0;
         dirty_q <= 1'b0;
         excl_q <= 1'b0;
         beats <= 2'd0;
      end else begin
         if (acvalid && acready) kind_q <= acsnoop;
         if (cache_ack) dirty_q <= cache_state == SMR_LS_UD || cache_state == SMR_LS_SD;
         if (cache_ack) excl_q <= cache_excl;
         if (cdvalid && cdready) beats <= cdlast ? 2'd0 : beats + 2'd1;
      end
   end
   // Snoop kinds that may never leave a unique copy.
   assign rd_multi = kind_q == SMR_SN_READ_SHARED || kind_q == SMR_SN_READ_CLEAN
      || kind_q == SMR_SN_READ_NSD;
   assign end_dirty = cache_new_state == SMR_LS_UD || cache_new_state == SMR_LS_SD;
   a_cr_after_hs: assert property ($rose(crvalid) |-> snoop_busy && !acready)
      else $error("response raised outside a snoop");
   a_busy_start: assert property (acvalid && acready |=> snoop_busy && !acready)
      else $error("snoop not taken after handshake");
   a_resp_hold: assert property (crvalid && !crready |=> crvalid && $stable(crresp))
      else $error("response dropped or changed before ready");
   a_data_follows: assert property (crvalid && crready && crresp.data_xfer |=> cdvalid)
      else $error("data flag set but no data");
   a_no_data: assert property (crvalid && crready && !crresp.data_xfer |=>
      !cdvalid [*2])
      else $error("data sent without data flag");
   a_four_beats: assert property (cdvalid && cdready && cdlast |-> beats == 2'd3)
      else $error("last beat at wrong count");
   a_shared_kept: assert property (cache_upd |->
      crresp.is_shared == (cache_new_state != SMR_LS_I))
      else $error("shared bit does not match kept copy");
   a_dirty_data: assert property (cache_upd && dirty_q |-> crresp.data_xfer)
      else $error("dirty line answered without data");
   a_pass_dirty: assert property (cache_upd |->
      crresp.pass_dirty == (dirty_q && !end_dirty))
      else $error("pass dirty bit wrong for state change");
   a_no_unique: assert property (cache_upd && rd_multi |->
      !(cache_new_state inside {SMR_LS_UC, SMR_LS_UD}))
      else $error("line left unique");
   a_excl_kept: assert property (cache_upd && rd_multi && excl_q |->
      cache_new_state != SMR_LS_I)
      else $error("exclusive line dropped");
endmodule
bind smr_top smr_props u_props (.clk_sys(clk_sys), .reset(reset), .acvalid(acvalid),
   .acready(acready), .acsnoop(acsnoop), .crvalid(crvalid), .crready(crready), .crresp(crresp),
   .cdvalid(cdvalid), .cdready(cdready), .cdlast(cdlast), .cache_ack(cache_ack),
   .cache_state(cache_state), .cache_excl(cache_excl), .cache_upd(cache_upd),
   .cache_new_state(cache_new_state), .snoop_busy(snoop_busy));

// ===== smr_top.sv
`timescale 1ns/1ps
module smr_top
   import smr_pkg::*;
#(
   parameter int DATA_W = SMR_DATA_W,
   parameter int BEATS = SMR_BEATS,
   parameter bit WAIT_OWN_WRITES = 1'b0
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Snoop address channel.
   input wire logic acvalid,
   output logic acready,
   input wire logic [SMR_ADDR_W-1:0] acaddr,
   input wire logic [SMR_SNOOP_W-1:0] acsnoop,
   // Snoop response channel.
   output logic crvalid,
   input wire logic crready,
   output smr_resp_type crresp,
   // Snoop data channel.
   output logic cdvalid,
   input wire logic cdready,
   output logic [DATA_W-1:0] cddata,
   output logic cdlast,
   // Cache tag and data port.
   output logic cache_req,
   output logic [SMR_ADDR_W-1:0] cache_addr,
   input wire logic cache_ack,
   input wire smr_line_type cache_state,
   input wire logic cache_excl,
   input wire logic [DATA_W*BEATS-1:0] cache_line,
   output logic cache_upd,
   output smr_line_type cache_new_state,
   // Store-next guess from the core.
   input wire smr_hint_type store_hint,
   // Own writes started on the write-address channel and finished on the response.
   input wire smr_wreq_type wr_start,
   input wire logic wr_done,
   input wire logic [SMR_ID_W-1:0] wr_done_id,
   // Snoop in progress.
   output logic snoop_busy
);

   localparam int LINE_W = DATA_W * BEATS;
   localparam int BEAT_W = (BEATS > 1) ? $clog2(BEATS) : 1;
   localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BEATS - 1);
   localparam logic [BEAT_W-1:0] BEAT_ZERO = '0;
   localparam logic [BEAT_W-1:0] BEAT_ONE = BEAT_W'(1);

   smr_state_type state;
   logic [SMR_SNOOP_W-1:0] snoop_kind;
   smr_line_type init_state;
   logic init_excl;
   logic [LINE_W-1:0] line_buf;
   logic [BEAT_W-1:0] beat;
   logic line_wb_hit;
   logic any_hold;
   smr_plan_type plan;
   logic hold;
   logic wb_start;
   logic wb_seen;

   // Outcome of one snoop from snoop type, line state, exclusivity and hint.
   function automatic smr_plan_type smr_decide(
      input logic [SMR_SNOOP_W-1:0] kind,
      input smr_line_type s,
      input logic excl,
      input smr_hint_type hint
   );
      smr_plan_type p;
      p.end_state = s;
      p.resp = '0;
      p.resp.was_unique = smr_unique(s);
      p.resp.data_xfer = smr_valid(s);
      unique case (kind)
         SMR_SN_READ_ONCE: begin
            // Pass clean and keep the copy, even a Unique one.
            p.resp.is_shared = smr_valid(s);
         end
         SMR_SN_READ_SHARED, SMR_SN_READ_CLEAN, SMR_SN_READ_NSD: begin
            // Clean copies drop to SC; never left Unique.
            if (smr_valid(s)) begin
               p.end_state = smr_dirty(s) ? SMR_LS_SD : SMR_LS_SC;
               p.resp.is_shared = 1'b1;
            end
            // ReadClean keeps dirty here and passes clean.
            if (smr_dirty(s) && kind == SMR_SN_READ_SHARED &&
                  hint != SMR_HINT_SNOOPED) begin
               p.end_state = SMR_LS_SC;
               p.resp.pass_dirty = 1'b1;
            end
            // Invalidate only for a likely initiator store, not in an exclusive run.
            if (smr_dirty(s) && kind == SMR_SN_READ_NSD &&
                  hint == SMR_HINT_INITIATOR && !excl) begin
               p.end_state = SMR_LS_I;
               p.resp.pass_dirty = 1'b1;
               p.resp.is_shared = 1'b0;
            end
         end
         default: begin
            // Other snoop types keep the line; a dirty copy still goes out on the
            // data channel, so no snoop ever needs the write channels.
            p.resp.is_shared = smr_valid(s);
            p.resp.data_xfer = smr_dirty(s);
         end
      endcase
      return p;
   endfunction

   // Writes in flight, looked up by the line under snoop.
   smr_wtrack #(
      .ID_W(SMR_ID_W),
      .LINE_W(SMR_ADDR_W - SMR_LINE_OFF)
   ) u_wtrack (
      .clk_sys(clk_sys),
      .reset(reset),
      .start_valid(wr_start.valid),
      .start_id(wr_start.id),
      .start_line(wr_start.addr[SMR_ADDR_W-1:SMR_LINE_OFF]),
      .start_kind(wr_start.kind),
      .done_valid(wr_done),
      .done_id(wr_done_id),
      .query_line(cache_addr[SMR_ADDR_W-1:SMR_LINE_OFF]),
      .line_wb_hit(line_wb_hit),
      .any_hold(any_hold),
      .unique_busy()
   );

   // A passing-dirty answer waits for this line's memory update; the unique
   // writes never enter the hold, since they may themselves wait on snoops.
   assign plan = smr_decide(snoop_kind, init_state, init_excl, store_hint);
   assign wb_start = wr_start.valid &&
      (wr_start.kind inside {SMR_WR_BACK, SMR_WR_CLEAN, SMR_WR_EVICT});
   assign hold = (plan.resp.pass_dirty && (line_wb_hit || wb_start || wb_seen)) ||
      (WAIT_OWN_WRITES && any_hold);

   // A write-back started in the last two cycles is not yet in the registered
   // tracker answer, so a passing-dirty reply waits for it as well.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wb_seen <= 1'b0;
      end else begin
         wb_seen <= wb_start;
      end
   end

   // Snoop sequence. No own read or unique write appears here, so snoops
   // always progress and the master's reads may stall behind them.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= SMR_ST_IDLE;
         acready <= 1'b0;
         crvalid <= 1'b0;
         crresp <= '0;
         cdvalid <= 1'b0;
         cdlast <= 1'b0;
         beat <= BEAT_ZERO;
         cache_req <= 1'b0;
         cache_upd <= 1'b0;
         cache_new_state <= SMR_LS_I;
         snoop_busy <= 1'b0;
      end else begin
         cache_upd <= 1'b0;
         unique case (state)
            SMR_ST_IDLE: begin
               if (acvalid && acready) begin
                  acready <= 1'b0;
                  cache_req <= 1'b1;
                  snoop_busy <= 1'b1;
                  state <= SMR_ST_LOOKUP;
               end else begin
                  acready <= 1'b1;
               end
            end
            SMR_ST_LOOKUP: begin
               // The tracker answer for this line is ready by the next cycle.
               if (cache_ack) begin
                  cache_req <= 1'b0;
                  state <= SMR_ST_DECIDE;
               end
            end
            SMR_ST_DECIDE: begin
               if (!hold) begin
                  crvalid <= 1'b1;
                  crresp <= plan.resp;
                  cache_upd <= 1'b1;
                  cache_new_state <= plan.end_state;
                  state <= SMR_ST_RESP;
               end
            end
            SMR_ST_RESP: begin
               if (crready) begin
                  crvalid <= 1'b0;
                  if (crresp.data_xfer) begin
                     // Data follows only when bit 0 said so.
                     cdvalid <= 1'b1;
                     cdlast <= (LAST_BEAT == BEAT_ZERO);
                     beat <= BEAT_ZERO;
                     state <= SMR_ST_DATA;
                  end else begin
                     snoop_busy <= 1'b0;
                     state <= SMR_ST_IDLE;
                  end
               end
            end
            SMR_ST_DATA: begin
               if (cdready) begin
                  if (cdlast) begin
                     cdvalid <= 1'b0;
                     cdlast <= 1'b0;
                     snoop_busy <= 1'b0;
                     state <= SMR_ST_IDLE;
                  end else begin
                     beat <= beat + BEAT_ONE;
                     cdlast <= (beat + BEAT_ONE == LAST_BEAT);
                  end
               end
            end
         endcase
      end
   end

   // Snoop capture and line data; the whole line is held so that the
   // data channel never has to wait on the cache arrays.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         snoop_kind <= '0;
         cache_addr <= '0;
         init_state <= SMR_LS_I;
         init_excl <= 1'b0;
         line_buf <= '0;
         cddata <= '0;
      end else begin
         if (state == SMR_ST_IDLE && acvalid && acready) begin
            snoop_kind <= acsnoop;
            cache_addr <= acaddr;
         end
         if (state == SMR_ST_LOOKUP && cache_ack) begin
            init_state <= cache_state;
            init_excl <= cache_excl;
            line_buf <= cache_line;
         end
         if (state == SMR_ST_RESP && crready) begin
            cddata <= line_buf[DATA_W-1:0];
         end else if (state == SMR_ST_DATA && cdready && !cdlast) begin
            cddata <= line_buf[(beat + BEAT_ONE) * DATA_W +: DATA_W];
         end
      end
   end

endmodule

// ===== smr_top_bench.sv
`timescale 1ns/1ps
module smr_top_bench;
   import smr_pkg::*;
   localparam logic [SMR_ADDR_W-1:0] LINE_ADDR = 32'h0000_1240;
   logic clk_sys, reset, acvalid, acready, crvalid, crready, cdvalid, cdready, cdlast, slow;
   logic cache_req, cache_ack, cache_excl, cache_upd, wr_done, snoop_busy;
   logic [31:0] acaddr, cache_addr;
   logic [3:0] acsnoop;
   logic [2:0] wr_done_id;
   logic [63:0] cddata;
   logic [255:0] cache_line, got_line;
   smr_resp_type crresp, got_resp;
   smr_line_type cache_state, cache_new_state;
   smr_hint_type store_hint;
   smr_wreq_type wr_start;
   int got_beats, fail_count, n_compared, cycles;
   smr_top uut (.clk_sys(clk_sys), .reset(reset), .acvalid(acvalid), .acready(acready),
      .acaddr(acaddr), .acsnoop(acsnoop), .crvalid(crvalid), .crready(crready), .crresp(crresp),
      .cdvalid(cdvalid), .cdready(cdready), .cddata(cddata), .cdlast(cdlast),
      .cache_req(cache_req), .cache_addr(cache_addr), .cache_ack(cache_ack),
      .cache_state(cache_state), .cache_excl(cache_excl), .cache_line(cache_line),
      .cache_upd(cache_upd), .cache_new_state(cache_new_state), .store_hint(store_hint),
      .wr_start(wr_start), .wr_done(wr_done), .wr_done_id(wr_done_id), .snoop_busy(snoop_busy));
   smr_icx u_icx (.clk_sys(clk_sys), .reset(reset), .slow(slow), .crvalid(crvalid),
      .crready(crready), .crresp(crresp), .cdvalid(cdvalid), .cdready(cdready), .cddata(cddata),
      .cdlast(cdlast), .got_resp(got_resp), .got_line(got_line), .got_beats(got_beats));
   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // A hang is cut short well beyond the few hundred cycles the run needs.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Own write start and finish, always on id 1.
   task automatic own_write(input smr_wkind_type k, input logic [31:0] a);
      @(negedge clk_sys);
      wr_start = '{valid: 1'b1, id: 3'h1, addr: a, kind: k};
      @(negedge clk_sys);
      wr_start.valid = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic own_done();
      @(negedge clk_sys);
      wr_done = 1'b1;
      wr_done_id = 3'h1;
      @(negedge clk_sys);
      wr_done = 1'b0;
   endtask
   // One snoop; hold is the number of cycles the answer is checked held before the own write finishes.
   task automatic snoop(input logic [3:0] k, input smr_line_type st, input logic ex,
      input smr_hint_type h, input smr_line_type e_end, input logic [4:0] e_resp, input int hold);
      logic [255:0] line;
      int b0;
      int n;
      for (int b = 0; b < 4; b++) line[b*64 +: 64] = 64'h0101_0101_0101_0101 * (b + 1) + 64'(k);
      b0 = got_beats;
      @(negedge clk_sys);
      acvalid = 1'b1;
      acaddr = LINE_ADDR;
      acsnoop = k;
      store_hint = h;
      n = 0;
      while (acready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      acvalid = 1'b0;
      n = 0;
      while (cache_req !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      cache_ack = 1'b1;
      cache_state = st;
      cache_excl = ex;
      cache_line = line;
      @(negedge clk_sys);
      cache_ack = 1'b0;
      n = 1;
      if (hold > 0) begin
         repeat (hold) begin
            check(crvalid, 1'b0);
            @(negedge clk_sys);
         end
         own_done();
      end
      while (crvalid !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      if (hold == 0) check(n, 2);
      check(snoop_busy, 1'b1);
      check(cache_upd, 1'b1);
      check(cache_new_state, e_end);
      n = 0;
      while (acready !== 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      check(cache_addr, LINE_ADDR);
      check(got_resp, e_resp);
      check(got_beats - b0, e_resp[0] ? 4 : 0);
      if (e_resp[0]) check(got_line, line);
   endtask
   // Reset, then every read snoop kind across line states, stalls and own writes.
   initial begin
      {reset, acvalid, cache_ack, cache_excl, wr_done, slow} = 6'b10_0000;
      {acaddr, acsnoop, wr_done_id, cache_line} = '0;
      cache_state = SMR_LS_I;
      store_hint = SMR_HINT_UNKNOWN;
      wr_start = '0;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      repeat (2) @(negedge clk_sys);
      snoop(SMR_SN_READ_ONCE, SMR_LS_I, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_I, 5'h00, 0);
      snoop(SMR_SN_READ_ONCE, SMR_LS_UC, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_UC, 5'h19, 0);
      snoop(SMR_SN_READ_ONCE, SMR_LS_UD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_UD, 5'h19, 0);
      slow = 1'b1;
      snoop(SMR_SN_READ_ONCE, SMR_LS_SD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SD, 5'h09, 0);
      snoop(SMR_SN_READ_CLEAN, SMR_LS_UC, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SC, 5'h19, 0);
      snoop(SMR_SN_READ_CLEAN, SMR_LS_UD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SD, 5'h19, 0);
      snoop(SMR_SN_READ_SHARED, SMR_LS_SD, 1'b0, SMR_HINT_SNOOPED, SMR_LS_SD, 5'h09, 0);
      slow = 1'b0;
      snoop(SMR_SN_READ_NSD, SMR_LS_UD, 1'b0, SMR_HINT_INITIATOR, SMR_LS_I, 5'h15, 0);
      snoop(SMR_SN_READ_NSD, SMR_LS_UD, 1'b1, SMR_HINT_INITIATOR, SMR_LS_SD, 5'h19, 0);
      snoop(4'h4, SMR_LS_SC, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SC, 5'h08, 0);
      own_write(SMR_WR_BACK, LINE_ADDR);
      snoop(SMR_SN_READ_SHARED, SMR_LS_UD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SC, 5'h1D, 6);
      own_write(SMR_WR_BACK, LINE_ADDR + 32'h0000_0040);
      snoop(SMR_SN_READ_SHARED, SMR_LS_UD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SC, 5'h1D, 0);
      own_done();
      slow = 1'b1;
      own_write(SMR_WR_UNIQUE, LINE_ADDR);
      snoop(SMR_SN_READ_SHARED, SMR_LS_UD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SC, 5'h1D, 0);
      own_done();
      own_write(SMR_WR_LINE_UNIQUE, LINE_ADDR);
      snoop(SMR_SN_READ_ONCE, SMR_LS_SD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SD, 5'h09, 0);
      snoop(4'h4, SMR_LS_SD, 1'b0, SMR_HINT_UNKNOWN, SMR_LS_SD, 5'h09, 0);
      own_done();
      wrap_up();
   end
endmodule

// ===== smr_wtrack.sv
`timescale 1ns/1ps
module smr_wtrack
   import smr_pkg::*;
#(
   parameter int ID_W = SMR_ID_W,
   parameter int LINE_W = SMR_ADDR_W - SMR_LINE_OFF
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Own write started and finished.
   input wire logic start_valid,
   input wire logic [ID_W-1:0] start_id,
   input wire logic [LINE_W-1:0] start_line,
   input wire smr_wkind_type start_kind,
   input wire logic done_valid,
   input wire logic [ID_W-1:0] done_id,
   // Line under snoop and registered answers.
   input wire logic [LINE_W-1:0] query_line,
   output logic line_wb_hit,
   output logic any_hold,
   output logic unique_busy
);

   localparam int DEPTH = 1 << ID_W;

   logic [DEPTH-1:0] busy;
   logic [LINE_W-1:0] line_mem [DEPTH];
   smr_wkind_type kind_mem [DEPTH];
   logic next_hit;
   logic next_hold;
   logic next_unique;

   // One entry per write ID; a start in the same cycle as a done wins.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         busy <= '0;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            if (start_valid && start_id == ID_W'(i)) begin
               busy[i] <= 1'b1;
            end else if (done_valid && done_id == ID_W'(i)) begin
               busy[i] <= 1'b0;
            end
         end
      end
   end

   // Address and kind need no reset; busy qualifies them.
   always_ff @(posedge clk_sys) begin
      if (start_valid) begin
         line_mem[start_id] <= start_line;
         kind_mem[start_id] <= start_kind;
      end
   end

   // Compare every live write-back, clean or evict entry against the snooped line.
   always_comb begin
      next_hit = 1'b0;
      next_hold = 1'b0;
      next_unique = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
         if (busy[i]) begin
            unique case (kind_mem[i])
               SMR_WR_BACK, SMR_WR_CLEAN, SMR_WR_EVICT: begin
                  next_hold = 1'b1;
                  if (line_mem[i] == query_line) begin
                     next_hit = 1'b1;
                  end
               end
               SMR_WR_NOSNOOP, SMR_WR_EVICT_ONLY: begin
                  next_hold = 1'b1;
               end
               SMR_WR_UNIQUE, SMR_WR_LINE_UNIQUE: begin
                  next_unique = 1'b1;
               end
               SMR_WR_OTHER: begin
               end
            endcase
         end
      end
   end

   // Answers come from registers, one cycle after the query settles.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         line_wb_hit <= 1'b0;
         any_hold <= 1'b0;
         unique_busy <= 1'b0;
      end else begin
         line_wb_hit <= next_hit;
         any_hold <= next_hold;
         unique_busy <= next_unique;
      end
   end

endmodule
